// ---- erl_cfg.svh ----
// constants for the expander reset and link supervisor
`ifndef ERL_CFG_SVH
`define ERL_CFG_SVH
`define ERL_NUM_EXP 8
`define ERL_WORD_W 8
`define ERL_BIT_LAST 3'h7
`define ERL_BIT_STEP 3'h1
`define ERL_BIT_FIRST 3'h0
`define ERL_LINE_IDLE 1'b1
`define ERL_START_BIT 1'b0
`define ERL_MCLK_HZ 25000000
`define ERL_LINK_HZ 8000000
`define ERL_I2C_MIN_HZ 100000
`define ERL_I2C_MAX_HZ 400000
`define ERL_I2C_DIV_W 8
`define ERL_ADDR_HI_W 4
`define ERL_ADDR_LO_W 3
`define ERL_EXP_ZERO 0
`endif

// ---- erl_partner.sv ----
// link model of one expander
`timescale 1ns/1ps
`default_nettype none
module erl_partner (
  input wire logic wclk,
  input wire logic link_write_data,
  input wire logic go,
  input wire logic [7:0] tx,
  input wire logic bad,
  output logic link_read_data,
  output logic [9:0] got
);
  logic [10:0] sh;
  initial link_read_data = 1'b1;
  always @(posedge go)
  begin
    sh = {1'b1, ^tx ^ bad, tx, 1'b0};
    repeat (11)
    begin
      @(posedge wclk);
      #1 link_read_data = sh[0];
      sh = sh >> 1;
    end
  end
  initial
  begin
    got = 10'h000;
    forever
    begin
      @(negedge wclk);
      if (link_write_data === 1'b0)
        for (int k = 0; k < 10; k++)
          @(negedge wclk) got[k] = link_write_data;
    end
  end
endmodule : erl_partner
`default_nettype wire

// ---- erl_pkg.sv ----
// types for the expander reset and link supervisor
package erl_pkg;
  typedef enum logic [3:0]
  {
    ERL_S_IDLE = 4'h1,
    ERL_S_DATA = 4'h2,
    ERL_S_PAR = 4'h4,
    ERL_S_STOP = 4'h8
  } erl_lstate_t;
endpackage : erl_pkg

// ---- erl_properties.sv ----
// assertions on the supervisor ports
`timescale 1ns/1ps
`default_nettype none
module erl_properties #(
  parameter int N = 8,
  parameter int I2C_HZ = 400000
) (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic [N-1:0] MANDATORY,
  input wire logic SW_RESET_REQ,
  input wire logic [N-1:0] OPT_RESET_REQ,
  input wire logic SYSTEM_RESET_LINE_N_I,
  input wire logic SYSTEM_RESET_LINE_N_OE,
  input wire logic EXPANDER_ZERO_RESET_PIN_N,
  input wire logic [N-1:0] OPT_RESET_N_OE,
  input wire logic SYSTEM_RESET,
  input wire logic [N-1:0] CH_RESET,
  input wire logic [N-1:0] DETECTED,
  input wire logic [3:0] I2C_ADDR_HI,
  input wire logic [N*7-1:0] EXP_SLAVE_ADDR,
  input wire logic I2C_BIT_TICK
);
  localparam int TP = (25000000 + I2C_HZ - 1) / I2C_HZ;
  logic [N-1:0] mand;
  assign mand = MANDATORY | N'(1);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (SYS_RST);
  sequence s_missing;
    (mand & ~DETECTED) != '0;
  endsequence
  sequence s_line_low;
    !SYSTEM_RESET_LINE_N_I [*4];
  endsequence
  property p_oe; !SYS_RST |=> !SYSTEM_RESET_LINE_N_OE; endproperty
  a_oe: assert property (p_oe) else $error("line driven");
  property p_exp0;
    !SYS_RST |=> EXPANDER_ZERO_RESET_PIN_N == !$past(SW_RESET_REQ);
  endproperty
  a_exp0: assert property (p_exp0) else $error("exp0 pin");
  property p_missing; s_missing [*2] |-> SYSTEM_RESET; endproperty
  a_missing: assert property (p_missing) else $error("missing");
  property p_line; s_line_low |=> SYSTEM_RESET; endproperty
  a_line: assert property (p_line) else $error("line low");
  property p_opt_oe;
    !SYS_RST |=> OPT_RESET_N_OE == ($past(OPT_RESET_REQ) & ~$past(mand));
  endproperty
  a_opt_oe: assert property (p_opt_oe) else $error("opt oe");
  property p_mand; !SYS_RST |=> (CH_RESET & $past(mand)) == '0; endproperty
  a_mand: assert property (p_mand) else $error("mand reset");
  property p_addr;
    !SYS_RST |=> EXP_SLAVE_ADDR[6:0] == {$past(I2C_ADDR_HI), 3'h0} &&
      EXP_SLAVE_ADDR[N*7-1 -: 7] == {$past(I2C_ADDR_HI), 3'(N - 1)};
  endproperty
  a_addr: assert property (p_addr) else $error("address");
  property p_tick; I2C_BIT_TICK |-> ##TP I2C_BIT_TICK; endproperty
  a_tick: assert property (p_tick) else $error("bit tick");
endmodule : erl_properties
`default_nettype wire

// ---- erl_supervisor.sv ----
// reset supervision and per-expander link logic of the controller
`timescale 1ns/1ps
`default_nettype none
`include "erl_cfg.svh"
// How it works
// - expander zero always mandatory, on shared reset
// - missing mandatory expander holds system reset
// - mandatory expander pulling line low holds reset
// - optional expander reset clears only its channel
// - optional resets dedicated pins, mandatory share line
// - dedicated pin drives expander zero reset
// - three-wire link at 8 MHz, parity checked
// - one separate link per expander
// - management bus bit rate 100 to 400 kHz
// - address low bits equal expander number
// - expanders switch to supplied write clock
// - lost write clock resets expander, pulls line
module erl_supervisor #(
  parameter int N = `ERL_NUM_EXP,
  parameter int I2C_HZ = `ERL_I2C_MAX_HZ
) (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic LINK_CLK,
  input wire logic [N-1:0] MANDATORY,
  input wire logic SW_RESET_REQ,
  input wire logic [N-1:0] OPT_RESET_REQ,
  input wire logic SYSTEM_RESET_LINE_N_I,
  output logic SYSTEM_RESET_LINE_N_O,
  output logic SYSTEM_RESET_LINE_N_OE,
  output logic EXPANDER_ZERO_RESET_PIN_N,
  input wire logic [N-1:0] OPT_RESET_N_I,
  output logic [N-1:0] OPT_RESET_N_O,
  output logic [N-1:0] OPT_RESET_N_OE,
  output logic SYSTEM_RESET,
  output logic [N-1:0] CH_RESET,
  output logic [N-1:0] DETECTED,
  input wire logic [N*`ERL_WORD_W-1:0] TX_DATA,
  input wire logic [N-1:0] TX_REQ,
  output logic [N-1:0] TX_BUSY,
  output logic [N*`ERL_WORD_W-1:0] RX_DATA,
  output logic [N-1:0] RX_VALID,
  output logic [N-1:0] RX_ERR,
  output logic [N-1:0] LINK_WRITE_CLOCK,
  output logic [N-1:0] LINK_WRITE_DATA,
  input wire logic [N-1:0] LINK_READ_DATA,
  input wire logic [`ERL_ADDR_HI_W-1:0] I2C_ADDR_HI,
  output logic [N*(`ERL_ADDR_HI_W+`ERL_ADDR_LO_W)-1:0] EXP_SLAVE_ADDR,
  output logic I2C_BIT_TICK
);
  localparam int AW = `ERL_ADDR_HI_W + `ERL_ADDR_LO_W;
  localparam int W = `ERL_WORD_W;
  // least bit period: round the divide up
  localparam int I2C_DIV = (`ERL_MCLK_HZ + I2C_HZ - 1) / I2C_HZ;
  localparam logic [`ERL_I2C_DIV_W-1:0] I2C_LAST =
    `ERL_I2C_DIV_W'(I2C_DIV - 1);

  // ----------------------------------------------------------
  // reset supervision
  // ----------------------------------------------------------
  logic [N:0] ls1_q, ls2_q;
  logic drive_q, drive_d, ez_q, ez_d, hold_q, hold_d;
  logic [N-1:0] opt_oe_q, opt_oe_d, chr_q, chr_d, det_s;
  logic [N-1:0] mand;
  logic [`ERL_I2C_DIV_W-1:0] div_q, div_d;
  logic tick_q, tick_d;

  assign mand = {MANDATORY[N-1:1], 1'b1};
  always_comb
  begin
    // controller pulls shared line only while reset
    drive_d = 1'b0;
    // expander zero pin follows software reset
    ez_d = ~SW_RESET_REQ;
    // shared line low from any mandatory expander
    // expander with lost clock pulls line
    hold_d = (|(mand & ~det_s)) | ~ls2_q[N];
    opt_oe_d = OPT_RESET_REQ & ~mand;
    // optional reset affects only its channel
    chr_d = ~mand & (~ls2_q[N-1:0] | OPT_RESET_REQ);
    // bit tick within 100 to 400 kHz
    tick_d = (div_q == I2C_LAST);
    div_d = tick_d ? '0 : div_q + `ERL_I2C_DIV_W'(1);
  end
  always_ff @(posedge MCLK)
  begin
    ls1_q <= {SYSTEM_RESET_LINE_N_I, OPT_RESET_N_I};
    ls2_q <= ls1_q;
    if (SYS_RST)
    begin
      drive_q <= 1'b1;
      ez_q <= 1'b0;
      hold_q <= 1'b1;
      opt_oe_q <= '0;
      chr_q <= '1;
      div_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      drive_q <= drive_d;
      ez_q <= ez_d;
      hold_q <= hold_d;
      opt_oe_q <= opt_oe_d;
      chr_q <= chr_d;
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

  // line is open drain, released unless resetting
  assign SYSTEM_RESET_LINE_N_O = 1'b0;
  assign SYSTEM_RESET_LINE_N_OE = drive_q;
  assign EXPANDER_ZERO_RESET_PIN_N = ez_q;
  assign OPT_RESET_N_O = '0;
  assign OPT_RESET_N_OE = opt_oe_q;
  assign SYSTEM_RESET = hold_q;
  assign CH_RESET = chr_q;
  assign I2C_BIT_TICK = tick_q;

  // ----------------------------------------------------------
  // per-expander links
  // ----------------------------------------------------------
  // one independent link per expander
  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_ch
      logic rq_q, rq_d, a1_q, a2_q, v1_q, v2_q, v3_q, d1_q, d2_q;
      logic rxv_q, rxv_d, rxe_q, rxe_d;
      logic [W-1:0] tw_q, tw_d, rxd_q, rxd_d;
      logic [AW-1:0] adr_q;
      logic lr1_q, lr2_q, q1_q, q2_q, ack_q, ack_d, wd_q, wd_d;
      logic rd1_q, rd2_q, tpar_q, tpar_d, rpar_q, rpar_d;
      logic perr_q, perr_d, rerr_q, rerr_d, rtg_q, rtg_d;
      logic det_q, det_d;
      logic [2:0] tc_q, tc_d, rc_q, rc_d;
      logic [W-1:0] tsh_q, tsh_d, rsh_q, rsh_d, rw_q, rw_d;
      erl_pkg::erl_lstate_t ts_q, ts_d, rs_q, rs_d;
      always_comb
      begin
        rq_d = rq_q;
        tw_d = tw_q;
        if (TX_REQ[i] && (rq_q == a2_q))
        begin
          rq_d = ~rq_q;
          tw_d = TX_DATA[i*W +: W];
        end
        rxv_d = (v2_q != v3_q);
        rxe_d = rxv_d & rerr_q;
        rxd_d = rxv_d ? rw_q : rxd_q;
      end
      always_ff @(posedge MCLK)
      begin
        a1_q <= ack_q;
        a2_q <= a1_q;
        v1_q <= rtg_q;
        v2_q <= v1_q;
        d1_q <= det_q;
        d2_q <= d1_q;
        // low address bits are the expander number
        adr_q <= {I2C_ADDR_HI, `ERL_ADDR_LO_W'(i)};
        if (SYS_RST || chr_q[i])
        begin
          rq_q <= 1'b0;
          tw_q <= '0;
          v3_q <= v2_q;
          rxv_q <= 1'b0;
          rxe_q <= 1'b0;
          rxd_q <= '0;
        end
        else
        begin
          rq_q <= rq_d;
          tw_q <= tw_d;
          v3_q <= v2_q;
          rxv_q <= rxv_d;
          rxe_q <= rxe_d;
          rxd_q <= rxd_d;
        end
      end
      assign det_s[i] = d2_q;
      assign DETECTED[i] = d2_q;
      assign TX_BUSY[i] = (rq_q != a2_q);
      assign RX_VALID[i] = rxv_q;
      assign RX_ERR[i] = rxe_q;
      assign RX_DATA[i*W +: W] = rxd_q;
      assign EXP_SLAVE_ADDR[i*AW +: AW] = adr_q;
      assign LINK_WRITE_CLOCK[i] = LINK_CLK;
      assign LINK_WRITE_DATA[i] = wd_q;
      // start, eight bits, even parity, stop
      always_comb
      begin
        ts_d = ts_q;
        tsh_d = tsh_q;
        tc_d = tc_q;
        tpar_d = tpar_q;
        ack_d = ack_q;
        wd_d = `ERL_LINE_IDLE;
        case (ts_q)
          erl_pkg::ERL_S_IDLE:
          begin
            if (q2_q != ack_q)
            begin
              tsh_d = tw_q;
              ack_d = q2_q;
              wd_d = `ERL_START_BIT;
              tc_d = `ERL_BIT_FIRST;
              tpar_d = 1'b0;
              ts_d = erl_pkg::ERL_S_DATA;
            end
          end
          erl_pkg::ERL_S_DATA:
          begin
            wd_d = tsh_q[0];
            tpar_d = tpar_q ^ tsh_q[0];
            tsh_d = tsh_q >> 1;
            tc_d = tc_q + `ERL_BIT_STEP;
            if (tc_q == `ERL_BIT_LAST)
              ts_d = erl_pkg::ERL_S_PAR;
          end
          erl_pkg::ERL_S_PAR:
          begin
            wd_d = tpar_q;
            ts_d = erl_pkg::ERL_S_STOP;
          end
          default:
            ts_d = erl_pkg::ERL_S_IDLE;
        endcase
      end

      // receiver checks parity and stop bit
      always_comb
      begin
        rs_d = rs_q;
        rsh_d = rsh_q;
        rc_d = rc_q;
        rpar_d = rpar_q;
        perr_d = perr_q;
        rerr_d = rerr_q;
        rw_d = rw_q;
        rtg_d = rtg_q;
        det_d = det_q;
        case (rs_q)
          erl_pkg::ERL_S_IDLE:
          begin
            if (rd2_q == `ERL_START_BIT)
            begin
              rc_d = `ERL_BIT_FIRST;
              rpar_d = 1'b0;
              rs_d = erl_pkg::ERL_S_DATA;
            end
          end
          erl_pkg::ERL_S_DATA:
          begin
            rsh_d = {rd2_q, rsh_q[W-1:1]};
            rpar_d = rpar_q ^ rd2_q;
            rc_d = rc_q + `ERL_BIT_STEP;
            if (rc_q == `ERL_BIT_LAST)
              rs_d = erl_pkg::ERL_S_PAR;
          end
          erl_pkg::ERL_S_PAR:
          begin
            perr_d = rpar_q ^ rd2_q;
            rs_d = erl_pkg::ERL_S_STOP;
          end
          erl_pkg::ERL_S_STOP:
          begin
            rerr_d = perr_q | (rd2_q != `ERL_LINE_IDLE);
            rw_d = rsh_q;
            rtg_d = ~rtg_q;
            // good frame marks the expander present
            if (!rerr_d)
              det_d = 1'b1;
            rs_d = erl_pkg::ERL_S_IDLE;
          end
          default:
            rs_d = erl_pkg::ERL_S_IDLE;
        endcase
      end

      always_ff @(posedge LINK_CLK)
      begin
        // channel reset synchronised into link domain
        lr1_q <= chr_q[i];
        lr2_q <= lr1_q;
        q1_q <= rq_q;
        q2_q <= q1_q;
        rd1_q <= LINK_READ_DATA[i];
        rd2_q <= rd1_q;
        // channel reset clears this link only
        if (lr2_q)
        begin
          ts_q <= erl_pkg::ERL_S_IDLE;
          rs_q <= erl_pkg::ERL_S_IDLE;
          ack_q <= 1'b0;
          wd_q <= `ERL_LINE_IDLE;
          tsh_q <= '0;
          tc_q <= `ERL_BIT_FIRST;
          tpar_q <= 1'b0;
          rsh_q <= '0;
          rc_q <= `ERL_BIT_FIRST;
          rpar_q <= 1'b0;
          perr_q <= 1'b0;
          rerr_q <= 1'b0;
          rw_q <= '0;
          det_q <= 1'b0;
          rtg_q <= 1'b0;
        end
        else
        begin
          ts_q <= ts_d;
          rs_q <= rs_d;
          ack_q <= ack_d;
          wd_q <= wd_d;
          tsh_q <= tsh_d;
          tc_q <= tc_d;
          tpar_q <= tpar_d;
          rsh_q <= rsh_d;
          rc_q <= rc_d;
          rpar_q <= rpar_d;
          perr_q <= perr_d;
          rerr_q <= rerr_d;
          rw_q <= rw_d;
          det_q <= det_d;
          rtg_q <= rtg_d;
        end
      end
    end
  endgenerate
endmodule : erl_supervisor
`default_nettype wire

// ---- erl_supervisor_bench.sv ----
// testbench of the expander reset and link supervisor
`timescale 1ns/1ps
`default_nettype none
module erl_supervisor_bench;
  logic mclk = 1'b0, lclk = 1'b0, rst = 1'b1, sw = 1'b0, pull = 1'b0;
  logic [7:0] mand = 8'h01, oreq = 8'h00, treq = 8'h00, go = 8'h00;
  logic [63:0] td = 64'h0, pd = 64'h0;
  logic [3:0] hi = 4'hA;
  logic loe, e0n, sr;
  logic [7:0] bad = 8'h00;
  logic [7:0] oe, chr, det, wc, wd, busy, rxv, rxe;
  logic [63:0] rxd;
  wire [7:0] rd;
  wire [9:0] got [8];
  // controller output enable and the bench pull signal both pull the line
  wire line = ~(loe | pull);
  int mismatches = 0, total_checks = 0;
  initial forever #20 mclk = ~mclk;
  initial #5 forever #16 lclk = ~lclk;
  erl_supervisor u_dut (.MCLK(mclk), .SYS_RST(rst), .LINK_CLK(lclk),
    .MANDATORY(mand), .SW_RESET_REQ(sw), .OPT_RESET_REQ(oreq),
    .SYSTEM_RESET_LINE_N_I(line), .SYSTEM_RESET_LINE_N_O(),
    .SYSTEM_RESET_LINE_N_OE(loe), .EXPANDER_ZERO_RESET_PIN_N(e0n),
    .OPT_RESET_N_I(~oe), .OPT_RESET_N_O(), .OPT_RESET_N_OE(oe),
    .SYSTEM_RESET(sr), .CH_RESET(chr), .DETECTED(det), .TX_DATA(td),
    .TX_REQ(treq), .TX_BUSY(busy), .RX_DATA(rxd), .RX_VALID(rxv),
    .RX_ERR(rxe),
    .LINK_WRITE_CLOCK(wc), .LINK_WRITE_DATA(wd), .LINK_READ_DATA(rd),
    .I2C_ADDR_HI(hi), .EXP_SLAVE_ADDR(), .I2C_BIT_TICK());
  for (genvar i = 0; i < 8; i++)
  begin : g_exp
    erl_partner u_exp (.wclk(wc[i]), .link_write_data(wd[i]), .go(go[i]),
      .tx(pd[i*8+:8]), .bad(bad[i]), .link_read_data(rd[i]), .got(got[i]));
  end
  task automatic chk(string what, logic [63:0] e, logic [63:0] s);
    total_checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("ERROR %s expected %0h seen %0h", what, e, s);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic hang(int k, int lim);
    if (k >= lim)
    begin
      mismatches++;
      $display("ERROR wait expected done seen timeout");
      report_and_stop();
    end
  endtask : hang
  task automatic t_detect;
    int k;
    chk("system_reset", 1, sr);
    @(posedge mclk);
    mand <= 8'h0F;
    pd <= 64'h3736353433323130;
    go <= 8'hFF;
    @(posedge mclk);
    go <= 8'h00;
    for (k = 0; k < 300 && det !== 8'hFF; k++)
      @(negedge mclk);
    hang(k, 300);
    repeat (3) @(negedge mclk);
    chk("system_reset", 0, sr);
    chk("rx_data", pd, rxd);
    $display("detect done");
  endtask : t_detect
  task automatic t_line;
    int k;
    @(posedge mclk);
    pull <= 1'b1;
    for (k = 0; k < 10 && sr !== 1'b1; k++)
      @(negedge mclk);
    hang(k, 10);
    chk("system_reset", 1, sr);
    repeat (4) @(posedge mclk);
    pull <= 1'b0;
    for (k = 0; k < 10 && sr !== 1'b0; k++)
      @(negedge mclk);
    hang(k, 10);
    $display("line done");
  endtask : t_line
  task automatic t_opt;
    @(posedge mclk);
    mand <= 8'h0E;
    oreq <= 8'h83;
    sw <= 1'b1;
    repeat (3) @(negedge mclk);
    chk("opt_oe", 8'h80, oe);
    chk("ch_reset", 8'h80, chr);
    chk("exp0_oe", 0, oe[0]);
    chk("system_reset", 0, sr);
    chk("exp0_pin", 0, e0n);
    @(posedge mclk);
    oreq <= 8'h00;
    sw <= 1'b0;
    repeat (2) @(negedge mclk);
    chk("opt_oe", 0, oe);
    chk("exp0_pin", 1, e0n);
    $display("optional done");
  endtask : t_opt
  task automatic t_tx;
    int k;
    @(posedge mclk);
    td[47:40] <= 8'hC5;
    treq <= 8'h20;
    @(posedge mclk);
    treq <= 8'h00;
    @(negedge mclk);
    chk("tx_busy", 8'h20, busy);
    for (k = 0; k < 100 && got[5] !== 10'h2C5; k++)
      @(negedge mclk);
    hang(k, 100);
    chk("other_link", 0, got[4]);
    chk("tx_busy", 0, busy);
    $display("transmit done");
  endtask : t_tx
  task automatic t_err;
    int k;
    @(posedge mclk);
    pd[55:48] <= 8'h5A;
    bad <= 8'h40;
    go <= 8'h40;
    @(posedge mclk);
    go <= 8'h00;
    for (k = 0; k < 100 && rxv[6] !== 1'b1; k++)
      @(negedge mclk);
    hang(k, 100);
    chk("rx_err", 1, rxe[6]);
    @(posedge mclk);
    bad <= 8'h00;
    go <= 8'h40;
    @(posedge mclk);
    go <= 8'h00;
    for (k = 0; k < 100 && rxv[6] !== 1'b1; k++)
      @(negedge mclk);
    hang(k, 100);
    chk("rx_err", 0, rxe[6]);
    chk("rx_data", 8'h5A, rxd[55:48]);
    $display("error check done");
  endtask : t_err
  initial
  begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    repeat (30) @(negedge mclk);
    t_detect();
    t_line();
    t_opt();
    t_tx();
    t_err();
    report_and_stop();
  end
endmodule : erl_supervisor_bench
bind erl_supervisor erl_properties #(.N(N), .I2C_HZ(I2C_HZ)) u_chk (
  .MCLK(MCLK), .SYS_RST(SYS_RST), .MANDATORY(MANDATORY),
  .SW_RESET_REQ(SW_RESET_REQ), .OPT_RESET_REQ(OPT_RESET_REQ),
  .SYSTEM_RESET_LINE_N_I(SYSTEM_RESET_LINE_N_I),
  .SYSTEM_RESET_LINE_N_OE(SYSTEM_RESET_LINE_N_OE),
  .EXPANDER_ZERO_RESET_PIN_N(EXPANDER_ZERO_RESET_PIN_N),
  .OPT_RESET_N_OE(OPT_RESET_N_OE), .SYSTEM_RESET(SYSTEM_RESET),
  .CH_RESET(CH_RESET), .DETECTED(DETECTED), .I2C_ADDR_HI(I2C_ADDR_HI),
  .EXP_SLAVE_ADDR(EXP_SLAVE_ADDR), .I2C_BIT_TICK(I2C_BIT_TICK));
`default_nettype wire
